// [wsc_map.svh]
// Constant map of the wiper setting command logic.
`ifndef WSC_MAP_SVH
`define WSC_MAP_SVH
`define WSC_OP_NOP        4'h0
`define WSC_OP_RESTORE    4'h1
`define WSC_OP_STORE      4'h2
`define WSC_OP_SHR_ONE    4'h3
`define WSC_OP_SHR_ALL    4'h4
`define WSC_OP_DEC_ONE    4'h5
`define WSC_OP_DEC_ALL    4'h6
`define WSC_OP_RELOAD_ALL 4'h7
`define WSC_OP_SHL_ONE    4'h8
`define WSC_OP_SHL_ALL    4'h9
`define WSC_OP_INC_ONE    4'hA
`define WSC_OP_INC_ALL    4'hB
`define WSC_FS_WIDE       9'h1FF
`define WSC_FS_NARROW     9'h07F
`define WSC_SETTING_RESET 9'h000
`define WSC_USER_BASE     4'h5
`define WSC_POT_PREFIX    5'h0B
`define WSC_MEM_PREFIX    5'h14
`define WSC_STORE_TIME_MS 25
`define WSC_CLK_KHZ       40000
`endif

// [wsc_pkg.sv]
// Types shared by the wiper setting command logic.
package wsc_pkg;
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] chan;
  } wsc_cmd_t;
  typedef enum logic [2:0] {S_RELOAD, S_LAND, S_IDLE, S_MEMRD, S_STORE} wsc_state_t;
endpackage : wsc_pkg

// [wsc_nv_mem.sv]
// Nonvolatile storage model: settings and user bytes, registered read.
`timescale 1ns/1ps
module wsc_nv_mem #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock.
  input  wire logic                     clk,
  // Access port.
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  input  wire logic                     we,
  input  wire logic [WIDTH-1:0]         wdata,
  output logic      [WIDTH-1:0]         rdata
);
  // No reset on purpose: the contents must survive every reset.
  logic [WIDTH-1:0] cells [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      cells[addr] <= wdata;
    end
    rdata <= cells[addr];
  end
endmodule : wsc_nv_mem

// [wsc_core.sv]
// Command interpreter and setting registers of the three-channel potentiometer.
//
// How it works
// - Wiper taps follow setting registers, unlimited rewrites.
// - Power-on reloads all settings from storage.
// - Store copies one setting; busy about 25 ms.
// - Restore reloads one, holds read state until the next command, user byte write or reset pin.
// - Command seven reloads all settings like reset.
// - Commands five, ten, six, eleven step by one.
// - Shift left doubles, shift right halves settings.
// - All-channel shifts change three channels together.
// - Left shift of zero gives code one.
// - Left shift at midscale or above gives full-scale.
// - Right shift drops low bit; zero stays.
// - User bytes use the general memory format.
// - Two memory select pins set memory address.
// - Undriven write-protect reads as protected.
// - Two address pins complete the slave address.
// - Low write-protect blocks only nonvolatile writes.
// - Reset pin refreshes settings from storage.
// - Channels zero and one are nine bits.
// - Channel two is seven bits, scaled limits.
`timescale 1ns/1ps
`include "wsc_map.svh"
module wsc_core
  import wsc_pkg::*;
#(
  parameter int unsigned STORE_CYCLES = `WSC_STORE_TIME_MS * `WSC_CLK_KHZ
) (
  // Clock and power-on reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Pins from outside the clock domain.
  input  wire logic       resetPinN,
  input  wire logic       writeProtectN,
  input  wire logic       bus_select_pin_0,
  input  wire logic       bus_select_pin_1,
  input  wire logic       memory_select_pin_hi,
  input  wire logic       memory_select_pin_lo,
  // Decoded bus front end.
  input  wire logic       addrValid,
  input  wire logic [6:0] addrByte,
  output logic            addrAck,
  output logic            memAck,
  input  wire logic       cmdValid,
  input  wire wsc_cmd_t   cmd,
  input  wire logic       wrValid,
  input  wire logic [1:0] wrChan,
  input  wire logic [8:0] wrData,
  input  wire logic       userValid,
  input  wire logic       userWrite,
  input  wire logic [3:0] userAddr,
  input  wire logic [7:0] userWData,
  output logic [7:0]      userRData,
  output logic            userRValid,
  // Wiper taps and status.
  output logic [8:0]      wiperSetting0,
  output logic [8:0]      wiperSetting1,
  output logic [6:0]      wiperSetting2,
  output logic            busy,
  output logic            memReadState,
  output logic            cmdDone
);
  localparam logic [31:0] STORE_LAST = 32'(STORE_CYCLES - 1);

  function automatic logic [8:0] fsOf(input logic [1:0] ch);
    fsOf = (ch == 2'h2) ? `WSC_FS_NARROW : `WSC_FS_WIDE;
  endfunction : fsOf

  function automatic logic [8:0] applyOp(input logic [3:0] op, input logic [8:0] v,
                                         input logic [8:0] fs);
    logic [8:0] mid;
    mid = (fs >> 1) + 9'h001;
    case (op)
      `WSC_OP_INC_ONE, `WSC_OP_INC_ALL: applyOp = (v == fs) ? v : v + 9'h001;
      `WSC_OP_DEC_ONE, `WSC_OP_DEC_ALL: applyOp = (v == 9'h000) ? v : v - 9'h001;
      `WSC_OP_SHL_ONE, `WSC_OP_SHL_ALL: begin
        if (v == 9'h000) begin
          applyOp = 9'h001;
        end else if (v >= mid) begin
          applyOp = fs;
        end else begin
          applyOp = v << 1;
        end
      end
      `WSC_OP_SHR_ONE, `WSC_OP_SHR_ALL: applyOp = v >> 1;
      default: applyOp = v;
    endcase
  endfunction : applyOp

  // Pin synchronisers; the first stage feeds only the second.
  logic [5:0] pinMeta;
  logic [5:0] pinSync;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta <= 6'h01;
      pinSync <= 6'h01;
    end else begin
      pinMeta <= {memory_select_pin_hi, memory_select_pin_lo, bus_select_pin_1,
                  bus_select_pin_0, writeProtectN, resetPinN};
      pinSync <= pinMeta;
    end
  end
  logic resetSyncN;
  logic wpOk;
  assign resetSyncN = pinSync[0];
  // A floating pin is pulled low outside, so protection is the default.
  assign wpOk       = pinSync[1];

  wsc_state_t  state;
  wsc_state_t  next_state;
  logic [8:0]  setting [3];
  logic [8:0]  next_setting [3];
  logic [1:0]  idx;
  logic [1:0]  next_idx;
  logic [1:0]  rdIdx;
  logic [1:0]  next_rdIdx;
  logic        rdPend;
  logic        next_rdPend;
  logic        toMemRd;
  logic        next_toMemRd;
  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_userRValid;
  logic [3:0]  memAddr;
  logic        memWe;
  logic [8:0]  memWData;
  logic [8:0]  memRData;

  wsc_nv_mem #(.WIDTH(9), .DEPTH(16)) nvMem (
    .clk   (clk),
    .addr  (memAddr),
    .we    (memWe),
    .wdata (memWData),
    .rdata (memRData)
  );

  always_comb begin
    next_state      = state;
    next_setting    = setting;
    next_idx        = idx;
    next_rdIdx      = idx;
    next_rdPend     = 1'b0;
    next_toMemRd    = toMemRd;
    next_count      = count;
    next_userRValid = 1'b0;
    memAddr         = 4'h0;
    memWe           = 1'b0;
    memWData        = 9'h000;
    cmdDone         = 1'b0;
    if (rdPend) begin
      next_setting[rdIdx] = memRData & fsOf(rdIdx);
    end
    case (state)
      S_RELOAD: begin
        memAddr     = {2'h0, idx};
        next_rdPend = 1'b1;
        next_rdIdx  = idx;
        if (idx == 2'h2) begin
          next_state = S_LAND;
        end else begin
          next_idx = idx + 2'h1;
        end
      end
      S_LAND: begin
        next_state = toMemRd ? S_MEMRD : S_IDLE;
        cmdDone    = 1'b1;
      end
      S_STORE: begin
        if (count == 32'h0) begin
          next_state = S_IDLE;
          cmdDone    = 1'b1;
        end else begin
          next_count = count - 32'h1;
        end
      end
      S_IDLE, S_MEMRD: begin
        if (!resetSyncN) begin
          next_state   = S_RELOAD;
          next_idx     = 2'h0;
          next_toMemRd = 1'b0;
        end else if (cmdValid) begin
          next_state   = S_IDLE;
          next_toMemRd = 1'b0;
          cmdDone      = 1'b1;
          case (cmd.op)
            `WSC_OP_RESTORE: begin
              if (cmd.chan != 2'h3) begin
                memAddr      = {2'h0, cmd.chan};
                next_rdPend  = 1'b1;
                next_rdIdx   = cmd.chan;
                next_toMemRd = 1'b1;
                next_state   = S_LAND;
                cmdDone      = 1'b0;
              end
            end
            `WSC_OP_STORE: begin
              if (cmd.chan != 2'h3 && wpOk) begin
                memAddr    = {2'h0, cmd.chan};
                memWe      = 1'b1;
                memWData   = setting[cmd.chan];
                next_count = STORE_LAST;
                next_state = S_STORE;
                cmdDone    = 1'b0;
              end
            end
            `WSC_OP_RELOAD_ALL: begin
              next_state = S_RELOAD;
              next_idx   = 2'h0;
              cmdDone    = 1'b0;
            end
            `WSC_OP_SHR_ALL, `WSC_OP_DEC_ALL, `WSC_OP_SHL_ALL, `WSC_OP_INC_ALL: begin
              for (int i = 0; i < 3; i++) begin
                next_setting[i] = applyOp(cmd.op, setting[i], fsOf(2'(i)));
              end
            end
            `WSC_OP_SHR_ONE, `WSC_OP_DEC_ONE, `WSC_OP_SHL_ONE, `WSC_OP_INC_ONE: begin
              if (cmd.chan != 2'h3) begin
                next_setting[cmd.chan] = applyOp(cmd.op, setting[cmd.chan], fsOf(cmd.chan));
              end
            end
            default: begin
            end
          endcase
        end else if (wrValid && wrChan != 2'h3) begin
          next_setting[wrChan] = wrData & fsOf(wrChan);
        end else if (userValid && userAddr >= `WSC_USER_BASE) begin
          memAddr  = userAddr;
          memWe    = userWrite && wpOk;
          memWData = {1'b0, userWData};
          next_userRValid = !userWrite;
          if (memWe) begin
            next_count = STORE_LAST;
            next_state = S_STORE;
          end
        end
      end
      default: next_state = S_RELOAD;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= S_RELOAD;
      setting    <= '{default: `WSC_SETTING_RESET};
      idx        <= 2'h0;
      rdIdx      <= 2'h0;
      rdPend     <= 1'b0;
      toMemRd    <= 1'b0;
      count      <= 32'h0;
      userRValid <= 1'b0;
    end else begin
      state      <= next_state;
      setting    <= next_setting;
      idx        <= next_idx;
      rdIdx      <= next_rdIdx;
      rdPend     <= next_rdPend;
      toMemRd    <= next_toMemRd;
      count      <= next_count;
      userRValid <= next_userRValid;
    end
  end

  assign wiperSetting0 = setting[0];
  assign wiperSetting1 = setting[1];
  assign wiperSetting2 = setting[2][6:0];
  assign userRData     = memRData[7:0];
  assign busy          = (state != S_IDLE) && (state != S_MEMRD);
  assign memReadState  = (state == S_MEMRD);
  assign addrAck = addrValid && (state != S_STORE) &&
                   (addrByte == {`WSC_POT_PREFIX, pinSync[3], pinSync[2]});
  assign memAck  = addrValid && (state != S_STORE) &&
                   (addrByte == {`WSC_MEM_PREFIX, pinSync[5], pinSync[4]});

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic accept;
  assign accept = cmdValid && resetSyncN && (state == S_IDLE || state == S_MEMRD);

  sequence restoreTaken;
    accept && cmd.op == `WSC_OP_RESTORE && cmd.chan != 2'h3;
  endsequence
  sequence nopTaken;
    accept && cmd.op == `WSC_OP_NOP;
  endsequence

  no_ack_writing_a: assert property (state == S_STORE |-> !addrAck && !memAck)
    else $error("address acknowledged during write");
  step_saturates_a: assert property (accept && cmd.op == `WSC_OP_INC_ONE && cmd.chan == 2'h0
    && setting[0] == 9'h1FF |=> setting[0] == 9'h1FF)
    else $error("increment passed full-scale");
  shl_zero_a: assert property (accept && cmd.op == `WSC_OP_SHL_ALL && setting[1] == 9'h000
    |=> setting[1] == 9'h001)
    else $error("left shift of zero not one");
  shl_top_a: assert property (accept && cmd.op == `WSC_OP_SHL_ALL && setting[2] >= 9'h040
    |=> setting[2] == 9'h07F)
    else $error("left shift at midscale not full-scale");
  shr_half_a: assert property (accept && cmd.op == `WSC_OP_SHR_ALL
    |=> setting[0] == ($past(setting[0]) >> 1) && setting[1] == ($past(setting[1]) >> 1))
    else $error("right shift wrong");
  wp_blocks_a: assert property (!wpOk |-> !memWe)
    else $error("write while protected");
  reload_ends_a: assert property (accept && cmd.op == `WSC_OP_RELOAD_ALL
    |=> busy [*4] ##1 (state == S_IDLE))
    else $error("reload did not finish in five cycles");
  restore_hold_a: assert property (restoreTaken |=> ##1 memReadState)
    else $error("restore did not enter read state");
  nop_leaves_a: assert property (nopTaken |=> !memReadState)
    else $error("no-op left read state set");
  store_len_a: assert property ($rose(state == S_STORE) |-> busy [*8])
    else $error("store ended too soon");
endmodule : wsc_core

// [wsc_ctl_model.sv]
// Bus controller model: issues shortcut commands and polls for acknowledge.
`timescale 1ns/1ps
module wsc_ctl_model
  import wsc_pkg::*;
(
  // Clock.
  input  wire logic       clk,
  // Decoded front end towards the core.
  output logic            cmdValid,
  output wsc_cmd_t        cmd,
  output logic            addrValid,
  output logic [6:0]      addrByte,
  input  wire logic       addrAck,
  input  wire logic       memAck
);
  initial begin
    cmdValid  = 1'b0;
    cmd       = '0;
    addrValid = 1'b0;
    addrByte  = 7'h7F;
  end
  // Released fields show the inverse of their last value so nothing stale passes.
  task automatic issue(input logic [3:0] op, input logic [1:0] chan);
    @(negedge clk);
    cmdValid = 1'b1;
    cmd      = '{op: op, chan: chan};
    @(negedge clk);
    cmdValid = 1'b0;
    cmd      = ~cmd;
  endtask : issue
  task automatic probe(input logic [6:0] addr, output logic pa, output logic ma);
    @(negedge clk);
    addrValid = 1'b1;
    addrByte  = addr;
    #1;
    pa = addrAck;
    ma = memAck;
    @(negedge clk);
    addrValid = 1'b0;
    addrByte  = ~addr;
  endtask : probe
  // The controller keeps asking until the device answers again or 200 retries have passed.
  task automatic pollAck(input logic [6:0] addr, output int waits);
    logic pa;
    logic ma;
    waits = 0;
    probe(addr, pa, ma);
    while (pa !== 1'b1 && waits < 200) begin
      waits++;
      probe(addr, pa, ma);
    end
  endtask : pollAck
endmodule : wsc_ctl_model

// [wsc_core_tb.sv]
// Self-checking testbench of the wiper setting command logic.
`timescale 1ns/1ps
`include "wsc_map.svh"
module wsc_core_tb;
  import wsc_pkg::*;
  logic       clk, rst, resetPinN, wpDrive, wpLevel, sel0, sel1, memHi, memLo;
  logic       wrValid, userValid, userWrite, cmdValid, addrValid, addrAck, memAck;
  logic       userRValid, busy, memReadState, cmdDone;
  logic [1:0] wrChan;
  logic [8:0] wrData, w0, w1;
  logic [6:0] w2, addrByte;
  logic [3:0] userAddr;
  logic [7:0] userWData, userRData;
  wsc_cmd_t   cmd;
  tri0        writeProtectN;
  int         nFail, checkCount, cyc, nDone;
  // Pull-down on the protect pin: undriven means protected.
  assign writeProtectN = wpDrive ? wpLevel : 1'bz;
  wsc_core #(.STORE_CYCLES(10)) wsc_core_i (.clk(clk), .rst(rst), .resetPinN(resetPinN),
    .writeProtectN(writeProtectN), .bus_select_pin_0(sel0), .bus_select_pin_1(sel1),
    .memory_select_pin_hi(memHi), .memory_select_pin_lo(memLo), .addrValid(addrValid),
    .addrByte(addrByte), .addrAck(addrAck), .memAck(memAck), .cmdValid(cmdValid),
    .cmd(cmd), .wrValid(wrValid), .wrChan(wrChan), .wrData(wrData), .userValid(userValid),
    .userWrite(userWrite), .userAddr(userAddr), .userWData(userWData),
    .userRData(userRData), .userRValid(userRValid), .wiperSetting0(w0),
    .wiperSetting1(w1), .wiperSetting2(w2), .busy(busy), .memReadState(memReadState),
    .cmdDone(cmdDone));
  wsc_ctl_model wsc_ctl_model_i (.clk(clk), .cmdValid(cmdValid), .cmd(cmd),
    .addrValid(addrValid), .addrByte(addrByte), .addrAck(addrAck), .memAck(memAck));
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic chk3(input logic [8:0] a, input logic [8:0] b, input logic [8:0] c);
    check(w0, a);
    check(w1, b);
    check({2'h0, w2}, c);
  endtask : chk3
  task automatic waitIdle;
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
    check({8'h0, busy}, 9'h000);
  endtask : waitIdle
  task automatic setw(input logic [1:0] c, input logic [8:0] d);
    @(negedge clk);
    {wrValid, wrChan, wrData} = {1'b1, c, d};
    @(negedge clk);
    {wrValid, wrChan, wrData} = {1'b0, ~c, ~d};
  endtask : setw
  task automatic set3(input logic [8:0] a, input logic [8:0] b, input logic [8:0] c);
    setw(2'h0, a);
    setw(2'h1, b);
    setw(2'h2, c);
  endtask : set3
  task automatic run(input logic [3:0] op, input logic [1:0] chan);
    int d0;
    d0 = nDone;
    wsc_ctl_model_i.issue(op, chan);
    waitIdle();
    repeat (3) @(negedge clk);
    // Every accepted command must report completion exactly once.
    check(9'(nDone - d0), 9'h001);
  endtask : run
  task automatic storeOne(input logic [1:0] c);
    int waits;
    wsc_ctl_model_i.issue(`WSC_OP_STORE, c);
    wsc_ctl_model_i.pollAck({`WSC_POT_PREFIX, sel1, sel0}, waits);
    check(9'(waits > 2 && waits < 20), 9'h001);
    waitIdle();
  endtask : storeOne
  task automatic t_store;
    set3(9'h1A5, 9'h0FF, 9'h055);
    for (int c = 0; c < 3; c++) storeOne(2'(c));
    set3(9'h000, 9'h000, 9'h000);
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    waitIdle();
    chk3(9'h1A5, 9'h0FF, 9'h055);
    set3(9'h000, 9'h000, 9'h000);
    resetPinN = 1'b0;
    repeat (6) @(negedge clk);
    resetPinN = 1'b1;
    repeat (3) @(negedge clk);
    waitIdle();
    chk3(9'h1A5, 9'h0FF, 9'h055);
    set3(9'h000, 9'h000, 9'h000);
    run(`WSC_OP_RELOAD_ALL, 2'h0);
    chk3(9'h1A5, 9'h0FF, 9'h055);
    setw(2'h1, 9'h000);
    run(`WSC_OP_RESTORE, 2'h1);
    check(w1, 9'h0FF);
    check({8'h0, memReadState}, 9'h001);
    run(`WSC_OP_NOP, 2'h0);
    check({8'h0, memReadState}, 9'h000);
    $display("done store and reload");
  endtask : t_store
  task automatic t_steps;
    set3(9'h1FE, 9'h001, 9'h07F);
    run(`WSC_OP_INC_ONE, 2'h0);
    run(`WSC_OP_INC_ONE, 2'h0);
    chk3(9'h1FF, 9'h001, 9'h07F);
    run(`WSC_OP_DEC_ALL, 2'h0);
    run(`WSC_OP_DEC_ALL, 2'h0);
    chk3(9'h1FD, 9'h000, 9'h07D);
    run(`WSC_OP_INC_ALL, 2'h0);
    run(`WSC_OP_DEC_ONE, 2'h2);
    chk3(9'h1FE, 9'h001, 9'h07D);
    $display("done steps");
  endtask : t_steps
  task automatic t_shifts;
    logic [8:0] tin [8] = '{9'h000, 9'h080, 9'h100, 9'h1FF, 9'h005, 9'h1FF, 9'h000, 9'h003};
    logic [8:0] tex [8] = '{9'h001, 9'h100, 9'h1FF, 9'h1FF, 9'h00A, 9'h0FF, 9'h000, 9'h001};
    for (int i = 0; i < 8; i++) begin
      setw(2'h0, tin[i]);
      run(i < 5 ? `WSC_OP_SHL_ONE : `WSC_OP_SHR_ONE, 2'h0);
      check(w0, tex[i]);
    end
    set3(9'h0FF, 9'h000, 9'h040);
    run(`WSC_OP_SHL_ALL, 2'h0);
    chk3(9'h1FE, 9'h001, 9'h07F);
    run(`WSC_OP_SHR_ALL, 2'h0);
    chk3(9'h0FF, 9'h000, 9'h03F);
    $display("done shifts");
  endtask : t_shifts
  task automatic t_protect;
    wpDrive = 1'b0;
    setw(2'h0, 9'h123);
    repeat (3) @(negedge clk);
    run(`WSC_OP_STORE, 2'h0);
    setw(2'h0, 9'h000);
    run(`WSC_OP_RESTORE, 2'h0);
    check(w0, 9'h1A5);
    run(`WSC_OP_NOP, 2'h0);
    wpDrive = 1'b1;
    $display("done protect");
  endtask : t_protect
  task automatic t_addr;
    logic pa;
    logic ma;
    for (int k = 0; k < 4; k++) begin
      {sel1, sel0, memHi, memLo} = {2'(k), ~2'(k)};
      repeat (3) @(negedge clk);
      wsc_ctl_model_i.probe({`WSC_POT_PREFIX, 2'(k)}, pa, ma);
      check({7'h0, pa, ma}, 9'h002);
      wsc_ctl_model_i.probe({`WSC_POT_PREFIX, ~2'(k)}, pa, ma);
      check({7'h0, pa, ma}, 9'h000);
      wsc_ctl_model_i.probe({`WSC_MEM_PREFIX, ~2'(k)}, pa, ma);
      check({7'h0, pa, ma}, 9'h001);
    end
    $display("done address");
  endtask : t_addr
  task automatic t_user;
    int waits;
    for (int a = 5; a < 16; a += 10) begin
      @(negedge clk);
      {userValid, userWrite, userAddr, userWData} = {2'b11, 4'(a), 8'(a * 37)};
      @(negedge clk);
      userValid = 1'b0;
      wsc_ctl_model_i.pollAck({`WSC_POT_PREFIX, sel1, sel0}, waits);
      check(9'(waits > 2 && waits < 20), 9'h001);
      waitIdle();
      {userValid, userWrite} = 2'b10;
      @(negedge clk);
      check({userRValid, userRData}, {1'b1, 8'(a * 37)});
      userValid = 1'b0;
    end
    $display("done user bytes");
  endtask : t_user
  task automatic give_verdict;
    $display("checks %0d failures %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cmdDone === 1'b1) begin
      nDone++;
    end
    if (cyc == 20000) begin
      nFail++;
      give_verdict();
    end
  end
  initial begin
    {rst, resetPinN, wpDrive, wpLevel, sel0, sel1, memHi, memLo} = 8'b1111_0000;
    {wrValid, wrChan, wrData, userValid, userWrite, userAddr, userWData} = '0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    waitIdle();
    t_store();
    t_steps();
    t_shifts();
    t_protect();
    t_addr();
    t_user();
    give_verdict();
  end
endmodule : wsc_core_tb
